// ===== pcl_loader.sv
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module pcl_loader import pcl_pkg::*; #(
    parameter logic [31:0] POR_CYCLES    = POR_CYC,
    parameter logic [31:0] STATUS_CYCLES = STATUS_MIN_CYC,
    parameter logic [31:0] INIT_CYCLES   = INIT_MIN_CYC,
    parameter logic [31:0] USER_PERIODS  = USER_INIT_PERIODS
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_config_req_n,
    input  wire logic        i_load_clock,
    input  wire logic        i_user_init_clock,
    input  wire logic [31:0] i_data,
    input  wire logic        i_status_in,
    output logic             o_status_out,
    output logic             o_status_oe_n,
    output logic             o_load_done,
    output logic             o_init_done_out,
    output logic             o_init_done_oe_n,
    output logic             o_data_user_en,
    output logic      [31:0] o_word,
    output logic             o_word_valid
);

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection.
    // ------------------------------------------------------------
    logic [35:0] pins_s;
    logic        req_n_s;
    logic        ld_s;
    logic        uc_s;
    logic        sts_s;
    logic [31:0] data_s;
    logic        ld_d;
    logic        uc_d;

    // Data travels through the same two stages as the load clock, so the
    // captured word lines up with the edge that the host meant.
    pcl_sync #(.W(36)) u_sync (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_d    ({i_config_req_n, i_load_clock, i_user_init_clock, i_status_in, i_data}),
        .o_q    (pins_s)
    );

    assign req_n_s = pins_s[35];
    assign ld_s    = pins_s[34];
    assign uc_s    = pins_s[33];
    assign sts_s   = pins_s[32];
    assign data_s  = pins_s[31:0];

    // Previous synchronised levels for edge finding.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ld_d <= 1'b0;
            uc_d <= 1'b0;
        end else begin
            ld_d <= ld_s;
            uc_d <= uc_s;
        end
    end

    logic ld_rise;
    logic ld_fall;
    logic uc_rise;
    assign ld_rise = ld_s & ~ld_d;
    assign ld_fall = ~ld_s & ld_d;
    assign uc_rise = uc_s & ~uc_d;

    // ------------------------------------------------------------
    // Registers and state.
    // ------------------------------------------------------------
    pcl_ctrl_t   ctrl;
    logic [31:0] length;
    pcl_state_t  state;
    pcl_state_t  next_state;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [2:0]  phase;
    logic [31:0] word_cnt;
    logic [31:0] last_word;

    // ------------------------------------------------------------
    // Load datapath decode.
    // ------------------------------------------------------------
    logic [3:0]  ratio;
    logic        last_phase;
    logic        capture;
    logic [31:0] next_words;
    logic        done_edge;

    assign ratio      = f_ratio(ctrl);
    assign last_phase = ({1'b0, phase} == ratio - 4'h1);
    // A word is taken only on the first edge of its group; the remaining
    // edges only advance the group phase.
    assign capture    = (state == ST_LOAD) && ld_rise && sts_s && (phase == 3'h0);
    assign next_words = word_cnt + {31'h0, capture};
    // Completion waits for the tail edges of the last group to be spent.
    assign done_edge  = (state == ST_LOAD) && ld_rise && sts_s && last_phase
                        && (next_words == length);

    // ------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------
    logic req_low;
    logic cnt_inc;
    assign req_low = ~req_n_s;
    assign cnt_inc = (state == ST_DONE) ? ld_fall
                   : (state == ST_INIT && ctrl.user_clk_sel) ? uc_rise : 1'b1;

    // Next state; a falling request restarts from any state but power-on and clear.
    always_comb begin
        next_state = state;
        case (state)
            ST_POR: begin
                if (cnt >= POR_CYCLES - 32'h1) begin
                    next_state = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                if (cnt >= STATUS_CYCLES - 32'h1 && !req_low) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (done_edge) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (ld_fall && cnt == 32'(DONE_FALL_EDGES - 1)) begin
                    next_state = ctrl.user_clk_sel ? ST_INIT_DLY : ST_INIT;
                end
            end
            ST_INIT_DLY: begin
                if (cnt >= 32'(USER_EN_CYC - 1)) begin
                    next_state = ST_INIT;
                end
            end
            ST_INIT: begin
                if (ctrl.user_clk_sel ? (uc_rise && cnt == USER_PERIODS - 32'h1)
                                      : (cnt >= INIT_CYCLES - 32'h1)) begin
                    next_state = ST_USER;
                end
            end
            ST_USER: begin
                next_state = ST_USER;
            end
            default: begin
                next_state = ST_POR;
            end
        endcase
        if (state != ST_POR && state != ST_CLEAR && req_low) begin
            next_state = ST_CLEAR;
        end
    end

    assign next_cnt = (next_state != state) ? 32'h0 : cnt + {31'h0, cnt_inc};

    // State and its cycle or edge counter.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_POR;
            cnt   <= 32'h0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Word capture; the group phase restarts with every new cycle. After
    // completion the load clock no longer touches anything here.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            phase        <= 3'h0;
            word_cnt     <= 32'h0;
            last_word    <= 32'h0;
            o_word       <= 32'h0;
            o_word_valid <= 1'b0;
        end else begin
            o_word_valid <= capture;
            if (state == ST_CLEAR) begin
                phase    <= 3'h0;
                word_cnt <= 32'h0;
            end else if (state == ST_LOAD && ld_rise && sts_s) begin
                phase    <= last_phase ? 3'h0 : phase + 3'h1;
                word_cnt <= next_words;
            end
            if (capture) begin
                last_word <= data_s & f_mask(ctrl.width);
                o_word    <= data_s & f_mask(ctrl.width);
            end
        end
    end

    // ------------------------------------------------------------
    // Pin outputs, all registered.
    // ------------------------------------------------------------
    logic in_config;
    assign in_config = (state == ST_LOAD) || (state == ST_DONE) || (state == ST_INIT_DLY)
                       || (state == ST_INIT);

    // Status and init-complete are open drain: the drive value stays low
    // and only the enable moves.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_status_out     <= 1'b0;
            o_status_oe_n    <= 1'b0;
            o_load_done      <= 1'b0;
            o_init_done_out  <= 1'b0;
            o_init_done_oe_n <= 1'b1;
            o_data_user_en   <= 1'b0;
        end else begin
            o_status_out     <= 1'b0;
            o_status_oe_n    <= !(next_state == ST_POR || next_state == ST_CLEAR);
            o_load_done      <= (next_state == ST_DONE) || (next_state == ST_INIT_DLY)
                                || (next_state == ST_INIT) || (next_state == ST_USER);
            o_init_done_out  <= 1'b0;
            o_init_done_oe_n <= !(ctrl.init_done_en && in_config);
            o_data_user_en   <= (state == ST_USER);
        end
    end

    // ------------------------------------------------------------
    // Wishbone classic slave.
    // ------------------------------------------------------------
    logic        wb_req;
    logic        wb_wr;
    logic        ctrl_open;
    logic [31:0] rd_data;
    logic [31:0] sts_word;

    assign wb_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    // A write lands on the acknowledging edge, while the master still holds it.
    assign wb_wr     = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
    // Settings only move outside a load so a word group never changes shape.
    assign ctrl_open = !in_config;
    assign sts_word  = {25'h0, (state == ST_USER), sts_s, o_load_done, 1'b0, state}; 
    assign rd_data   = (i_wb_adr == ADDR_CTRL)   ? {26'h0, ctrl}
                     : (i_wb_adr == ADDR_LENGTH) ? length
                     : (i_wb_adr == ADDR_STATUS) ? sts_word
                     : (i_wb_adr == ADDR_WORDS)  ? word_cnt
                     : (i_wb_adr == ADDR_LAST)   ? last_word : 32'h0;

    // One wait state: ack follows the request by one edge and drops after.
    // Writes take effect only in the ack cycle.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
            ctrl     <= CTRL_RESET;
            length   <= LENGTH_RESET;
        end else begin
            o_wb_ack <= wb_req;
            o_wb_dat <= wb_req ? rd_data : 32'h0;
            if (wb_wr && ctrl_open && i_wb_adr == ADDR_CTRL && i_wb_sel[0]) begin
                ctrl <= pcl_ctrl_t'(i_wb_dat[5:0]);
            end
            if (wb_wr && ctrl_open && i_wb_adr == ADDR_LENGTH) begin
                length <= f_lanes(length, i_wb_dat, i_wb_sel);
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    property p_ratio;
        @(posedge i_mclk) disable iff (i_rst)
        (ctrl.width == WIDTH_X32 && ctrl.decomp_en) |-> ratio == 4'h8;
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio wrong for x32 decompress");

    property p_req_low;
        @(posedge i_mclk) disable iff (i_rst)
        ($fell(req_n_s) && state != ST_POR) |-> ##[1:3] (!o_status_oe_n && !o_load_done);
    endproperty
    a_req_low: assert property (p_req_low) else $error("request fall not answered");

    property p_por;
        @(posedge i_mclk) disable iff (i_rst)
        (state == ST_POR) |=> !o_status_oe_n;
    endproperty
    a_por: assert property (p_por) else $error("status released during power-on");

    property p_done_low;
        @(posedge i_mclk) disable iff (i_rst)
        (state == ST_LOAD && next_state == ST_LOAD) |=> !o_load_done;
    endproperty
    a_done_low: assert property (p_done_low) else $error("load-complete high while loading");

    property p_done_rise;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(o_load_done) |-> word_cnt == length;
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("load-complete before image end");

    // Unbroken cycles of status pulled low, counted apart from the sequencer.
    logic [31:0] sts_low_cnt;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sts_low_cnt <= 32'h0;
        end else begin
            sts_low_cnt <= o_status_oe_n ? 32'h0 : sts_low_cnt + 32'h1;
        end
    end

    property p_status_min;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(o_status_oe_n) |-> sts_low_cnt >= STATUS_CYCLES;
    endproperty
    a_status_min: assert property (p_status_min) else $error("status low too short");

    property p_capture;
        @(posedge i_mclk) disable iff (i_rst)
        capture |=> (word_cnt == $past(word_cnt) + 32'h1) && o_word_valid
                    && (last_word == ($past(data_s) & f_mask(ctrl.width)));
    endproperty
    a_capture: assert property (p_capture) else $error("word not captured on rise");

    property p_spare_edge;
        @(posedge i_mclk) disable iff (i_rst)
        (state == ST_LOAD && ld_rise && phase != 3'h0) |=> $stable(word_cnt) && !o_word_valid;
    endproperty
    a_spare_edge: assert property (p_spare_edge) else $error("spare edge took a word");

    property p_init_done;
        @(posedge i_mclk) disable iff (i_rst)
        (ctrl.init_done_en && state == ST_INIT) |=> !o_init_done_oe_n;
    endproperty
    a_init_done: assert property (p_init_done) else $error("init-complete not driven low");

    property p_user_dly;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(state == ST_INIT_DLY) |-> (state == ST_INIT_DLY)[*4] ##1 (state == ST_INIT);
    endproperty
    a_user_dly: assert property (p_user_dly) else $error("user clock enable delay wrong");

    property p_int_init;
        @(posedge i_mclk) disable iff (i_rst)
        (state == ST_INIT && !ctrl.user_clk_sel && next_state == ST_USER)
            |-> cnt == INIT_CYCLES - 32'h1;
    endproperty
    a_int_init: assert property (p_int_init) else $error("internal init length wrong");

    property p_user_pins;
        @(posedge i_mclk) disable iff (i_rst)
        (state == ST_USER) |=> o_data_user_en && $stable(word_cnt);
    endproperty
    a_user_pins: assert property (p_user_pins) else $error("user mode pins or count wrong");

    property p_static;
        @(posedge i_mclk) disable iff (i_rst)
        (state == ST_LOAD) |=> $stable(ctrl);
    endproperty
    a_static: assert property (p_static) else $error("settings changed while loading");

endmodule

// ===== pcl_pkg.sv
// Contract
// - Clocks per word follow width and features
// - Extra load clocks per word do decryption work (here they are only counted; nothing decrypts)
// - Byte, 16 and 32 bit lanes from bit 0
// - Request low starts a new configuration cycle
// - Status held low through power-on delay
// - Load-complete low until configuration ends
// - Load-complete rises only after whole image
// - Init-complete driven low once option loaded
// - Load clock ignored after configuration completes
// - Request fall drives both lines low quickly
// - Status low 268 to 1506 us (only the 268 us minimum is enforced here; no maximum)
// - Data word captured on load clock rise
// - Internal init reaches user mode in window
// - User init clock delayed, then 8576 periods
// - Data pins freed for user after configuration
package pcl_pkg;

    // ------------------------------------------------------------
    // Clock and timing.
    // ------------------------------------------------------------
    localparam int CLK_MHZ                = 100;
    localparam int CLK_PERIOD_NS          = 10;
    localparam int T_REQ_LOW_MAX_NS       = 600;
    localparam int REQ_LOW_MAX_CYC        = T_REQ_LOW_MAX_NS / CLK_PERIOD_NS;
    localparam int T_POR_US               = 100;
    localparam int POR_CYC                = T_POR_US * CLK_MHZ;
    localparam int T_STATUS_MIN_US        = 268;
    localparam int T_STATUS_MAX_US        = 1506;
    localparam int STATUS_MIN_CYC         = T_STATUS_MIN_US * CLK_MHZ;
    localparam int STATUS_MAX_CYC         = T_STATUS_MAX_US * CLK_MHZ;
    localparam int T_INIT_MIN_US          = 175;
    localparam int T_INIT_MAX_US          = 437;
    localparam int INIT_MIN_CYC           = T_INIT_MIN_US * CLK_MHZ;
    localparam int LOAD_CLK_MAX_PERIOD_NS = 10;
    localparam int USER_EN_PERIODS        = 4;
    localparam int USER_EN_CYC            =
        (USER_EN_PERIODS * LOAD_CLK_MAX_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int USER_INIT_PERIODS      = 8576;
    localparam int DONE_FALL_EDGES        = 2;

    // ------------------------------------------------------------
    // Register map and fields.
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_LENGTH    = 8'h04;
    localparam logic [7:0]  ADDR_STATUS    = 8'h08;
    localparam logic [7:0]  ADDR_WORDS     = 8'h0c;
    localparam logic [7:0]  ADDR_LAST      = 8'h10;
    localparam logic [5:0]  CTRL_RESET     = 6'h00;
    localparam logic [31:0] LENGTH_RESET   = 32'h00000100;
    localparam int          STS_STATE_LSB  = 0;
    localparam int          STS_DONE_BIT   = 4;
    localparam int          STS_LINE_BIT   = 5;
    localparam int          STS_USER_BIT   = 6;
    localparam logic [1:0]  WIDTH_X8       = 2'h0;
    localparam logic [1:0]  WIDTH_X16      = 2'h1;
    localparam logic [1:0]  WIDTH_X32      = 2'h2;

    typedef struct packed {
        logic       user_clk_sel;
        logic       init_done_en;
        logic       secur_en;
        logic       decomp_en;
        logic [1:0] width;
    } pcl_ctrl_t;

    typedef enum logic [2:0] {
        ST_POR, ST_CLEAR, ST_LOAD, ST_DONE, ST_INIT_DLY, ST_INIT, ST_USER
    } pcl_state_t;

    // Load clocks spent on each data word.
    function automatic logic [3:0] f_ratio(input pcl_ctrl_t c);
        logic [3:0] base;
        base = (c.width == WIDTH_X32) ? 4'h4 : (c.width == WIDTH_X16) ? 4'h2 : 4'h1;
        if (c.decomp_en) begin
            f_ratio = {base[2:0], 1'b0};
        end else if (c.secur_en) begin
            f_ratio = base;
        end else begin
            f_ratio = 4'h1;
        end
    endfunction

    // Lanes of the data bus that carry the image at a given width.
    function automatic logic [31:0] f_mask(input logic [1:0] w);
        f_mask = (w == WIDTH_X32) ? 32'hffffffff : (w == WIDTH_X16) ? 32'h0000ffff
                                                                    : 32'h000000ff;
    endfunction

    // Byte-lane merge for Wishbone writes.
    function automatic logic [31:0] f_lanes(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            f_lanes[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

endpackage

// ===== pcl_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser; the first stage feeds only the second.
module pcl_sync #(
    parameter int W = 1
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta;

    // Both stages reset to zero so the request reads as asserted at power-up.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta <= '0;
            o_q  <= '0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule

// ===== pcl_host_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host that feeds an image over the parallel load link.
// ------------------------------------------------------------
module pcl_host_model (
    input  wire logic        i_status,
    output logic             o_config_req_n,
    output logic             o_load_clock,
    output logic      [31:0] o_data
);
    logic [31:0] sent[$];

    // Idle request high and load clock parked low between frames.
    initial begin
        o_config_req_n = 1'b1;  // Idle level.
        o_load_clock   = 1'b0;  // Never left floating.
        o_data         = 32'h0;
    end

    // One load clock period of 80 ns, inside the frequency ceiling.
    task automatic pulse();
        #40 o_load_clock = 1'b1;  // Slow enough for every width.
        #40 o_load_clock = 1'b0;
    endtask

    // Full configuration cycle of n words at r load clocks per word.
    task automatic run(input int n, input int r);
        #3 o_config_req_n = 1'b0;  // Off the system clock edge; starts a cycle.
        #2100 o_config_req_n = 1'b1;  // Long enough low pulse.
        wait (i_status === 1'b0);
        wait (i_status === 1'b1);
        #2003;  // Gap after status release, kept off the clock edge.
        for (int i = 0; i < n; i++) begin
            o_data = $urandom;
            sent.push_back(o_data);
            #(($urandom % 3) * 80);  // Random pause, clock held low, data ready.
            repeat (r) pulse();  // Word held for its whole group.
            o_data = ~o_data;  // Stale data never lingers.
        end
        repeat (2) pulse();  // The first of these falls, after the last word's fall, starts initialisation.
    endtask
endmodule

// ===== parallel_config_loader_tb_top.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Self-checking bench for the parallel configuration loader.
// ------------------------------------------------------------
module parallel_config_loader_tb_top import pcl_pkg::*;;
    logic        i_mclk = 1'b0, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        uclk = 1'b0, done_d = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, word, q, data;
    logic        ack, req_n, lclk, st_oe_n, st_out, done, id_oe_n, user_en, wvalid, id_out;
    wire         status_wire = st_oe_n ? 1'b1 : st_out;
    int          miscompares = 0, num_checks = 0, n_exp, seen;
    pcl_ctrl_t   ctrl = '0;

    // System clock and an unrelated user initialisation clock.
    always #5 i_mclk = ~i_mclk;
    always #43 uclk = ~uclk;

    pcl_loader #(.POR_CYCLES(32'h14), .STATUS_CYCLES(32'h1e), .INIT_CYCLES(32'h14),
                 .USER_PERIODS(32'h5)) DUT (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_config_req_n(req_n), .i_load_clock(lclk), .i_user_init_clock(uclk),
        .i_data(data), .i_status_in(status_wire), .o_status_out(st_out),
        .o_status_oe_n(st_oe_n), .o_load_done(done), .o_init_done_out(id_out),
        .o_init_done_oe_n(id_oe_n), .o_data_user_en(user_en), .o_word(word),
        .o_word_valid(wvalid));

    pcl_host_model u_host (.i_status(status_wire), .o_config_req_n(req_n),
                           .o_load_clock(lclk), .o_data(data));

    // Single comparison point; every mismatch is counted and reported.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Classic single Wishbone cycle; read data lands in q.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge i_mclk);
        t = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge i_mclk); while (ack !== 1'b1 && ++t < 50);
        if (t >= 50) miscompares++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Load clocks per word expected for a setting.
    function automatic int exp_ratio(input pcl_ctrl_t c);
        int b;
        b = (c.width == WIDTH_X32) ? 4 : (c.width == WIDTH_X16) ? 2 : 1;
        return c.decomp_en ? 2 * b : (c.secur_en ? b : 1);
    endfunction

    // Lanes that carry the image at a width; the rest must read zero.
    function automatic logic [31:0] exp_mask(input logic [1:0] w);
        return (w == WIDTH_X32) ? 32'hffffffff : (w == WIDTH_X16) ? 32'h0000ffff : 32'h000000ff;
    endfunction

    // Word monitor: each captured word against what the host sent.
    always @(posedge i_mclk) begin
        if (wvalid === 1'b1) begin
            seen++;
            chk(word, u_host.sent[seen-1] & exp_mask(ctrl.width), "word");
            chk(id_oe_n, !ctrl.init_done_en, "init line");
        end
        if (done === 1'b1 && done_d !== 1'b1) chk(seen, n_exp, "done early");
        done_d <= done;
    end

    task automatic close_out();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 55 us the sequence needs.
    initial begin
        #200000;
        miscompares++;
        close_out();
    end

    // Main sequence: reset values, then plain, security and decompression at every width.
    initial begin
        void'($urandom(32'hefac1687));
        repeat (4) @(posedge i_mclk);
        chk({st_oe_n, done, id_oe_n, user_en}, 4'b0010, "reset outs");
        i_rst <= 1'b0;
        wb(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'h0, "ctrl reset");
        wb(1'b0, ADDR_LENGTH, 32'h0);
        chk(q, LENGTH_RESET, "length reset");
        wb(1'b1, 8'h20, 32'hffffffff);
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0, "unmapped");
        for (int k = 0; k < 9; k++) begin
            ctrl = 6'($urandom);
            ctrl.width = 2'(k % 3);
            ctrl.decomp_en = (k / 3 == 2);
            ctrl.secur_en = (k / 3 == 1) || (k / 3 == 2 && ctrl.secur_en);
            // Corner cases: user clock init first, internal init with the line next.
            if (k < 2) {ctrl.user_clk_sel, ctrl.init_done_en} = {k == 0, k == 1};
            n_exp = 2 + $urandom % 4;
            wb(1'b1, ADDR_CTRL, 32'(ctrl));
            wb(1'b1, ADDR_LENGTH, 32'(n_exp));
            u_host.sent.delete();
            seen = 0;
            fork
                u_host.run(n_exp, exp_ratio(ctrl));
                begin
                    #595 chk({st_oe_n, done}, 2'b00, "request fall");
                    wait (seen == 1);
                    wb(1'b1, ADDR_CTRL, 32'(~ctrl));  // Refused while loading.
                end
            join
            for (int t = 0; t < 3000 && user_en !== 1'b1; t++) @(posedge i_mclk);
            chk({done, user_en, id_oe_n, id_out}, 4'b1110, "user mode");
            #3 repeat (3) u_host.pulse();  // Ignored after completion.
            wb(1'b0, ADDR_CTRL, 32'h0);
            chk(q, 32'(ctrl), "ctrl locked");
            wb(1'b0, ADDR_STATUS, 32'h0);
            chk(q, (32'h1 << STS_USER_BIT) | (32'h1 << STS_LINE_BIT)
                   | (32'h1 << STS_DONE_BIT) | 32'(ST_USER), "status reg");
            wb(1'b0, ADDR_WORDS, 32'h0);
            chk(q, 32'(n_exp), "word count");
            wb(1'b0, ADDR_LAST, 32'h0);
            chk(q, u_host.sent[n_exp-1] & exp_mask(ctrl.width), "last word");
            chk(seen, n_exp, "words seen");
        end
        close_out();
    end
endmodule
